/* verilog/pmc_pkg.sv */
// Constants shared by the power mode control block and its helpers.
// Assumes a 32-bit AHB-Lite register bus and a single core clock.
package pmc_pkg;
	localparam int unsigned PMC_AW          = 12;
	// Register indices; the byte address is four times the index
	localparam logic [9:0]  PMC_IDX_CTRL    = 10'h087;
	localparam logic [9:0]  PMC_IDX_STATUS  = 10'h088;
	localparam logic [9:0]  PMC_IDX_MASK    = 10'h089;
	localparam logic [9:0]  PMC_IDX_SCON7   = 10'h08a;
	localparam logic [11:0] PMC_ADDR_CTRL   = {PMC_IDX_CTRL, 2'h0};
	localparam logic [11:0] PMC_ADDR_STATUS = {PMC_IDX_STATUS, 2'h0};
	localparam logic [11:0] PMC_ADDR_MASK   = {PMC_IDX_MASK, 2'h0};
	localparam logic [11:0] PMC_ADDR_SCON7  = {PMC_IDX_SCON7, 2'h0};
	// Bit positions of the power mode control register
	localparam int unsigned PMC_B_BAUD      = 7;
	localparam int unsigned PMC_B_FESEL     = 6;
	localparam int unsigned PMC_B_RSVD      = 5;
	localparam int unsigned PMC_B_POF       = 4;
	localparam int unsigned PMC_B_GF1       = 3;
	localparam int unsigned PMC_B_GF0       = 2;
	localparam int unsigned PMC_B_PD        = 1;
	localparam int unsigned PMC_B_IDL       = 0;
	localparam logic [7:0]  PMC_CTRL_RESET  = 8'h00;
	// Serial control bit seven position in its window register
	localparam int unsigned PMC_B_SCON7     = 7;
	// Interrupt status and mask layout
	localparam int unsigned PMC_IRQ_W       = 3;
	localparam int unsigned PMC_IRQ_POF     = 0;
	localparam int unsigned PMC_IRQ_FE      = 1;
	localparam int unsigned PMC_IRQ_WAKE    = 2;
	localparam logic [2:0]  PMC_IRQ_RESET   = 3'h0;
	localparam logic [1:0]  PMC_HRESP_OKAY  = 2'h0;
	localparam logic [31:0] PMC_RD_ZERO     = 32'h0000_0000;
endpackage : pmc_pkg

/* verilog/pmc_sync.sv */
// Three-stage synchroniser for an asynchronous level, with a filtered
// level and a one-cycle rise pulse. Assumes one clock and an async reset.
`timescale 1ns/1ns
module pmc_sync (
	input  wire logic hclk,     // Core clock
	input  wire logic hresetn,  // Async reset, active low
	input  wire logic async_in, // Level from outside the clock domain
	output logic      level,    // Filtered level
	output logic      rise      // One-cycle pulse on a low to high change
);
	typedef struct packed {
		logic q1;
		logic q2;
		logic q3;
		logic level;
		logic rise;
	} pmc_sync_type;

	pmc_sync_type s;
	pmc_sync_type next_s;

	// Only the second stage reads the first one
	always_comb begin
		next_s = s;
		next_s.q1 = async_in;
		next_s.q2 = s.q1;
		next_s.q3 = s.q2;
		next_s.rise = 1'b0;
		if (s.q2 == s.q3) begin
			next_s.level = s.q3;
			next_s.rise = s.q3 & ~s.level;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign level = s.level;
	assign rise  = s.rise;
endmodule : pmc_sync

/* verilog/pmc_serial_control_reg_sel.sv */
// Storage behind serial control bit seven: serial mode bit zero and the
// framing error flag, one of which software reaches at a time.
// Assumes the serial receiver pulses fe_set on the same clock.
`timescale 1ns/1ns
module pmc_serial_control_reg_sel (
	input  wire logic hclk,        // Core clock
	input  wire logic hresetn,     // Async reset, active low
	input  wire logic select_fe,   // One: bit seven reaches the framing error flag
	input  wire logic wr_en,       // Software write of bit seven
	input  wire logic wr_bit,      // Value written
	input  wire logic fe_set,      // Receiver saw a bad stop bit
	output logic      mode_bit0,   // Serial mode bit zero
	output logic      frame_err,   // Framing error flag
	output logic      rd_bit       // Value software reads at bit seven
);
	typedef struct packed {
		logic mode_bit0;
		logic frame_err;
	} pmc_serial_control_reg_type;

	pmc_serial_control_reg_type s;
	pmc_serial_control_reg_type next_s;

	always_comb begin
		next_s = s;
		if (wr_en && select_fe) begin
			next_s.frame_err = wr_bit; // RL2
		end
		if (wr_en && !select_fe) begin
			next_s.mode_bit0 = wr_bit; // RL3
		end
		// A receiver error in the cycle of a software clear is kept
		if (fe_set) begin
			next_s.frame_err = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign mode_bit0 = s.mode_bit0;
	assign frame_err = s.frame_err;
	assign rd_bit    = select_fe ? s.frame_err : s.mode_bit0; // RL2 RL3
endmodule : pmc_serial_control_reg_sel

/* verilog/pmc_top.sv */
// Power mode control register with serial baud doubling, serial bit
// seven steering, power loss flag, sleep requests and an interrupt.
// Assumes an AHB-Lite master on hclk and a supply comparator on a pin.
`timescale 1ns/1ns

// Function
// RL1 - With the top bit set, the serial baud rate doubles when timer 1 clocks it in modes 1 to 3.
// RL2 - With the select bit set, serial control bit seven reads and writes the framing error flag.
// RL3 - With the select bit clear, serial control bit seven reads and writes serial mode bit zero.
// RL4 - Reserved bit five may read as anything; here it holds no state and reads zero.
// RL5 - Software must write zero to reserved bit five.
// RL6 - The power loss flag sets when the supply rises above 3 V.
// RL7 - Software may set or clear the power loss flag by writing it.
// RL8 - Writing one to a sleep bit enters it, a wake or reset leaves it, deep sleep wins.
module pmc_top
	import pmc_pkg::*;
(
	input  wire logic        hclk,              // Core clock, 250 MHz
	input  wire logic        hresetn,           // Async reset, active low
	input  wire logic        hsel,              // Slave select
	input  wire logic [31:0] haddr,             // Byte address
	input  wire logic [1:0]  htrans,            // Transfer type
	input  wire logic        hwrite,            // Write when high
	input  wire logic [2:0]  hsize,             // Transfer size, word only
	input  wire logic        hready,            // Bus ready
	input  wire logic [31:0] hwdata,            // Write data
	output logic      [31:0] hrdata,            // Read data
	output logic             hreadyout,         // Slave ready
	output logic             hresp,             // Response, always OKAY
	input  wire logic        vcc_above_3v,      // Supply comparator, async
	input  wire logic        wake_event,        // Interrupt to the core, pulse
	input  wire logic        timer1_baud_src,   // Timer 1 clocks the serial port
	input  wire logic        serial_mode_bit1,  // Serial mode bit one
	input  wire logic        framing_error_set, // Receiver framing error, pulse
	output logic             baud_doubler,      // Top register bit
	output logic             baud_x2_active,    // Serial port runs at double rate
	output logic             frame_err_select,  // Bit seven steering
	output logic             serial_mode_bit0,  // Serial mode bit zero
	output logic             framing_error_bit, // Framing error flag
	output logic             power_loss_flag,   // Power was lost
	output logic             deep_sleep_req,    // Powerdown request
	output logic             light_sleep_req,   // Idle request
	output logic             irq                // Level interrupt
);
	import pmc_pkg::*;

	typedef struct packed {
		logic                 baud_doubler;
		logic                 frame_err_select;
		logic                 power_loss_flag;
		logic                 user_flag_1;
		logic                 user_flag_0;
		logic                 deep_sleep_bit;
		logic                 light_sleep_bit;
		logic [PMC_IRQ_W-1:0] irq_status;
		logic [PMC_IRQ_W-1:0] irq_mask;
		logic                 wr_pend;
		logic [PMC_AW-1:0]    wr_addr;
		logic [31:0]          hrdata;
		logic                 hreadyout;
		logic                 irq;
		logic                 baud_x2_active;
		logic                 light_sleep_req;
	} pmc_state_type;

	pmc_state_type s;
	pmc_state_type next_s;

	logic                 supply_up;
	logic                 supply_rise;
	logic                 serial_control_reg_wr;
	logic                 serial_control_reg_rd_bit;
	logic                 sm0;
	logic                 fe;
	logic                 access;
	logic [PMC_AW-1:0]    rd_addr;
	logic [7:0]           ctrl_word;
	logic [PMC_IRQ_W-1:0] events;

	pmc_sync u_supply_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in (vcc_above_3v),
		.level    (supply_up),
		.rise     (supply_rise)
	);

	assign serial_control_reg_wr = s.wr_pend && (s.wr_addr == PMC_ADDR_SCON7);

	pmc_serial_control_reg_sel u_serial_control_reg_sel (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.select_fe (s.frame_err_select),
		.wr_en     (serial_control_reg_wr),
		.wr_bit    (hwdata[PMC_B_SCON7]),
		.fe_set    (framing_error_set),
		.mode_bit0 (sm0),
		.frame_err (fe),
		.rd_bit    (serial_control_reg_rd_bit)
	);

	// Reserved bit five has no flop behind it and reads zero
	always_comb begin
		ctrl_word = PMC_CTRL_RESET;
		ctrl_word[PMC_B_BAUD]  = s.baud_doubler;
		ctrl_word[PMC_B_FESEL] = s.frame_err_select;
		ctrl_word[PMC_B_POF]   = s.power_loss_flag;
		ctrl_word[PMC_B_GF1]   = s.user_flag_1;
		ctrl_word[PMC_B_GF0]   = s.user_flag_0;
		ctrl_word[PMC_B_PD]    = s.deep_sleep_bit;
		ctrl_word[PMC_B_IDL]   = s.light_sleep_bit; // RL4
	end

	assign access  = hsel & hready & htrans[1];
	assign rd_addr = haddr[PMC_AW-1:0];

	always_comb begin
		next_s = s;
		events = '0;
		events[PMC_IRQ_POF]  = supply_rise;
		events[PMC_IRQ_FE]   = framing_error_set;
		events[PMC_IRQ_WAKE] = wake_event & (s.deep_sleep_bit | s.light_sleep_bit);

		// Address phase: latch writes, prepare read data so the data
		// phase needs no wait state
		next_s.wr_pend   = access & hwrite;
		next_s.hreadyout = 1'b1;
		if (access) begin
			next_s.wr_addr = rd_addr;
		end
		if (access && !hwrite) begin
			unique case (rd_addr)
				PMC_ADDR_CTRL:   next_s.hrdata = {24'h000000, ctrl_word};
				PMC_ADDR_STATUS: next_s.hrdata = {29'h0, s.irq_status};
				PMC_ADDR_MASK:   next_s.hrdata = {29'h0, s.irq_mask};
				PMC_ADDR_SCON7:  next_s.hrdata = {24'h000000, serial_control_reg_rd_bit, 7'h00};
				default:         next_s.hrdata = PMC_RD_ZERO;
			endcase
		end

		// A wake ends either sleep mode
		if (wake_event) begin
			next_s.deep_sleep_bit  = 1'b0; // RL8
			next_s.light_sleep_bit = 1'b0; // RL8
		end

		// Data phase: commit the write; bit five is dropped
		if (s.wr_pend && s.wr_addr == PMC_ADDR_CTRL) begin // RL5
			next_s.baud_doubler     = hwdata[PMC_B_BAUD];
			next_s.frame_err_select = hwdata[PMC_B_FESEL];
			next_s.power_loss_flag  = hwdata[PMC_B_POF]; // RL7
			next_s.user_flag_1      = hwdata[PMC_B_GF1]; // RL8
			next_s.user_flag_0      = hwdata[PMC_B_GF0]; // RL8
			next_s.deep_sleep_bit   = hwdata[PMC_B_PD]; // RL8
			next_s.light_sleep_bit  = hwdata[PMC_B_IDL]; // RL8
		end
		if (s.wr_pend && s.wr_addr == PMC_ADDR_MASK) begin
			next_s.irq_mask = hwdata[PMC_IRQ_W-1:0];
		end

		// Hardware set wins over a software clear in the same cycle
		if (supply_rise) begin
			next_s.power_loss_flag = 1'b1; // RL6
		end

		// Status clears on read, but a new event in that cycle survives
		if (access && !hwrite && rd_addr == PMC_ADDR_STATUS) begin
			next_s.irq_status = events;
		end else begin
			next_s.irq_status = s.irq_status | events;
		end

		next_s.irq = |(next_s.irq_status & next_s.irq_mask);
		// Mode 0 is the shift-register mode, never doubled
		next_s.baud_x2_active = next_s.baud_doubler & timer1_baud_src
			& (sm0 | serial_mode_bit1); // RL1
		next_s.light_sleep_req = next_s.light_sleep_bit & ~next_s.deep_sleep_bit; // RL8
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.hreadyout <= 1'b1;
			s.irq_status <= PMC_IRQ_RESET;
			s.irq_mask <= PMC_IRQ_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign hrdata            = s.hrdata;
	assign hreadyout         = s.hreadyout;
	assign hresp             = PMC_HRESP_OKAY[0];
	assign baud_doubler      = s.baud_doubler;
	assign baud_x2_active    = s.baud_x2_active;
	assign frame_err_select  = s.frame_err_select;
	assign serial_mode_bit0  = sm0;
	assign framing_error_bit = fe;
	assign power_loss_flag   = s.power_loss_flag;
	assign deep_sleep_req    = s.deep_sleep_bit;
	assign light_sleep_req   = s.light_sleep_req;
	assign irq               = s.irq;
endmodule : pmc_top

/* verification/pmc_top_properties.sv */
// Port-level assertions for the power mode control block.
// Assumes it is bound into pmc_top on the single core clock.
`timescale 1ns/1ns
module pmc_top_properties
	import pmc_pkg::*;
(
	input wire logic        hclk,              // clock
	input wire logic        hresetn,           // reset
	input wire logic        hsel,              // select
	input wire logic [31:0] haddr,             // address
	input wire logic [1:0]  htrans,            // type
	input wire logic        hwrite,            // write
	input wire logic        hready,            // ready
	input wire logic [31:0] hwdata,            // wdata
	input wire logic        vcc_above_3v,      // supply
	input wire logic        wake_event,        // wake
	input wire logic        timer1_baud_src,   // timer
	input wire logic        serial_mode_bit1,  // mode
	input wire logic        framing_error_set, // fe in
	input wire logic        baud_doubler,      // bit7
	input wire logic        baud_x2_active,    // x2
	input wire logic        frame_err_select,  // bit6
	input wire logic        serial_mode_bit0,  // mode
	input wire logic        framing_error_bit, // fe
	input wire logic        power_loss_flag,   // pof
	input wire logic        deep_sleep_req,    // deep
	input wire logic        light_sleep_req    // light
);
	logic wr_ctl;
	logic wr_sc;
	wire  take = hsel && hready && htrans[1] && hwrite;
	// High through the data phase of a write, when the register takes it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ctl <= 1'b0;
			wr_sc  <= 1'b0;
		end else begin
			wr_ctl <= take && haddr[11:0] == PMC_ADDR_CTRL;
			wr_sc  <= take && haddr[11:0] == PMC_ADDR_SCON7;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence vcc_up_s;
		$rose(vcc_above_3v) ##1 vcc_above_3v[*3];
	endsequence
	// The control bit and the doubled rate leave the same flop edge
	baud_rate_a: assert property (
		baud_x2_active == (baud_doubler && $past(timer1_baud_src
		&& (serial_mode_bit0 || serial_mode_bit1)))) else $error("double rate wrong");
	sleep_prio_a: assert property (
		deep_sleep_req |-> !light_sleep_req) else $error("both sleeps requested");
	wake_exit_a: assert property (
		wake_event && !wr_ctl && deep_sleep_req |=> !deep_sleep_req && !light_sleep_req)
		else $error("wake left sleep set");
	pof_set_a: assert property (
		vcc_up_s |-> ##[0:3] power_loss_flag) else $error("power loss not flagged");
	pof_clear_a: assert property (
		$fell(power_loss_flag) |-> $past(wr_ctl)) else $error("power loss flag lost");
	ctrl_write_a: assert property (
		wr_ctl |=> baud_doubler == $past(hwdata[7]) && frame_err_select == $past(hwdata[6])
		&& deep_sleep_req == $past(hwdata[1])) else $error("control write lost");
	mode_bit_a: assert property (
		wr_sc && !frame_err_select |=> serial_mode_bit0 == $past(hwdata[7]))
		else $error("mode bit write lost");
	mode_hold_a: assert property (
		$changed(serial_mode_bit0) |-> $past(wr_sc && !frame_err_select))
		else $error("mode bit changed alone");
	fe_write_a: assert property (
		wr_sc && frame_err_select && !framing_error_set |=>
		framing_error_bit == $past(hwdata[7])) else $error("framing flag write lost");
	fe_set_a: assert property (
		framing_error_set |=> framing_error_bit) else $error("framing flag not set");
endmodule : pmc_top_properties

bind pmc_top pmc_top_properties u_props (.*);

/* verification/pmc_top_bench.sv */
// Self-checking bench for the power mode control block.
// Assumes pmc_top and its checker are compiled before it.
`timescale 1ns/1ns
`define CK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
	$display("wrong value at %0t: got %h want %h", $time, a, e); end end
module power_mode_control_bench;
	import pmc_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
	logic        vcc_above_3v = 1'b0, wake_event = 1'b0, timer1_baud_src = 1'b0;
	logic        serial_mode_bit1 = 1'b0, framing_error_set = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic        hreadyout, hresp, baud_doubler, baud_x2_active, frame_err_select;
	logic        serial_mode_bit0, framing_error_bit, power_loss_flag;
	logic        deep_sleep_req, light_sleep_req, irq;
	int          err_count = 0, checked = 0;
	always #2 hclk = ~hclk;
	assign hready = hreadyout;
	pmc_top u_dut (.*);
	// Two idle edges at the end keep write-then-read apart and let outputs settle
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {20'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		repeat (2) @(posedge hclk);
	endtask : bus
	task automatic rdck(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CK(rd, e)
	endtask : rdck
	task automatic t_reset;
		`CK({hreadyout, hresp, baud_doubler, frame_err_select, deep_sleep_req,
			light_sleep_req, power_loss_flag, irq}, 8'h80)
		rdck(PMC_ADDR_CTRL, 32'h0);
		rdck(12'h400, 32'h0);
	endtask : t_reset
	task automatic t_ctrl;
		bus(1'b1, PMC_ADDR_CTRL, 32'h0000_00df);
		`CK({deep_sleep_req, light_sleep_req, power_loss_flag}, 3'h5)
		rdck(PMC_ADDR_CTRL, 32'h0000_00df);
		wake_event <= 1'b1;
		@(posedge hclk);
		wake_event <= 1'b0;
		repeat (2) @(posedge hclk);
		`CK({deep_sleep_req, light_sleep_req}, 2'h0)
		rdck(PMC_ADDR_CTRL, 32'h0000_00dc);
		bus(1'b1, PMC_ADDR_CTRL, 32'h0000_0001);
		`CK(light_sleep_req, 1'b1)
		bus(1'b1, PMC_ADDR_CTRL, 32'h0);
		`CK(power_loss_flag, 1'b0)
	endtask : t_ctrl
	task automatic t_baud;
		bus(1'b1, PMC_ADDR_CTRL, 32'h0000_0080);
		for (int i = 0; i < 8; i++) begin
			timer1_baud_src  <= i[0];
			serial_mode_bit1 <= i[1];
			if (i == 4) bus(1'b1, PMC_ADDR_CTRL, 32'h0);
			repeat (3) @(posedge hclk);
			`CK(baud_x2_active, i[0] & i[1] & (i < 4))
		end
	endtask : t_baud
	task automatic t_serial_control_reg;
		bus(1'b1, PMC_ADDR_SCON7, 32'h0000_0080);
		`CK({serial_mode_bit0, framing_error_bit}, 2'h2)
		rdck(PMC_ADDR_SCON7, 32'h0000_0080);
		bus(1'b1, PMC_ADDR_CTRL, 32'h0000_0040);
		rdck(PMC_ADDR_SCON7, 32'h0);
		framing_error_set <= 1'b1;
		@(posedge hclk);
		framing_error_set <= 1'b0;
		rdck(PMC_ADDR_SCON7, 32'h0000_0080);
		bus(1'b1, PMC_ADDR_SCON7, 32'h0);
		`CK({serial_mode_bit0, framing_error_bit}, 2'h2)
		// Mode bit zero alone selects a doubled mode
		serial_mode_bit1 <= 1'b0;
		bus(1'b1, PMC_ADDR_CTRL, 32'h0000_00c0);
		`CK(baud_x2_active, 1'b1)
	endtask : t_serial_control_reg
	task automatic t_irq;
		rdck(PMC_ADDR_STATUS, 32'h0000_0006);
		vcc_above_3v <= 1'b1;
		repeat (8) @(posedge hclk);
		`CK({power_loss_flag, irq}, 2'h2)
		bus(1'b1, PMC_ADDR_MASK, 32'h0000_0001);
		`CK(irq, 1'b1)
		rdck(PMC_ADDR_STATUS, 32'h0000_0001);
		`CK(irq, 1'b0)
		bus(1'b1, PMC_ADDR_CTRL, 32'h0);
		`CK(power_loss_flag, 1'b0)
	endtask : t_irq
	task automatic test_done;
		if (err_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset;
		t_ctrl;
		t_baud;
		t_serial_control_reg;
		t_irq;
		test_done;
	end
	// The whole run needs about 125 cycles
	initial begin
		#20000;
		err_count++;
		test_done;
	end
endmodule : power_mode_control_bench
